// file: logic/oled_link_pkg.sv
// Purpose: shared constants and types for the two-wire display link
// Assumes: core clock of 125 MHz on both ends
// Notes: host register map and init byte table live here
//
// Functional notes
// - target address picked by address_select_bit level
// - direction bit one reads, zero writes
// - first byte after address: control or data
// - control byte: continuation, data/command, six zeros
// - continuation zero makes rest data-only
// - data/command zero to commands, one to memory
// - column pointer steps after each memory write
// - host starts init: off, column, row windows
// - host sets clock divide with parameter zero
// - host sends function selection with one
// - host ends with second pre-charge fifteen
// - strap low means other mode, port idle
// - chip_init_pin_n low initialises, else high
package oled_link_pkg;

  // ****************************************
  // target addressing and control byte
  // ****************************************
  localparam logic [6:0] TGT_ADDR_SEL_LOW = 7'h3C;
  localparam logic [6:0] TGT_ADDR_SEL_HIGH = 7'h3D;
  localparam int CONT_FLAG_POS = 7;
  localparam int DC_FLAG_POS = 6;
  localparam logic [5:0] CTRL_ZERO_BITS = 6'h00;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;

  // ****************************************
  // recommended power-up command stream
  // ****************************************
  localparam int INIT_LEN = 30;
  localparam logic [7:0] INIT_SEQ [INIT_LEN] = '{
    8'hAE, 8'h15, 8'h00, 8'h3F, 8'h75, 8'h00, 8'h7F, 8'h81,
    8'h9B, 8'hA0, 8'h51, 8'hA1, 8'h00, 8'hA2, 8'h00, 8'hA4,
    8'hA8, 8'h7F, 8'hAB, 8'h01, 8'hB1, 8'hF1, 8'hB3, 8'h00,
    8'hBC, 8'h07, 8'hBE, 8'h07, 8'hB6, 8'h0F};

  // ****************************************
  // host register map and fields
  // ****************************************
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_RXDATA = 2'h3;
  localparam int CTRL_GO_WR_POS = 0;
  localparam int CTRL_GO_RD_POS = 1;
  localparam int CTRL_GO_INIT_POS = 2;
  localparam int CTRL_DC_POS = 3;
  localparam int CTRL_SA_POS = 4;
  localparam int CTRL_INIT_N_POS = 5;
  localparam logic [2:0] CTRL_CFG_RESET = 3'h4;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_NACK_POS = 1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_NS = 8;
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int MIN_QTR_CYC = 8;
  localparam int FRAME_BYTES = 8192;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {LS_ADDR, LS_CTRL, LS_PAYLOAD, LS_READ,
    LS_IGNORE} link_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} host_state_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_INIT} host_op_t;

endpackage : oled_link_pkg

// file: logic/oled_link_if.sv
// Purpose: two-wire link between host end and display end
// Assumes: open-drain data line with pull-up, host drives clock
// Notes: the data line level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface oled_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;
  logic address_select_bit;
  logic chip_init_pin_n;
  logic interface_select_strap;

  // wired-and with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_out) |
    (dev_sda_oe & ~dev_sda_out));

  modport host (output scl, host_sda_out, host_sda_oe, address_select_bit,
    chip_init_pin_n, input sda);
  modport device (input scl, sda, address_select_bit, chip_init_pin_n,
    interface_select_strap, output dev_sda_out, dev_sda_oe);
endinterface : oled_link_if
`default_nettype wire

// file: logic/oled_dev_end.sv
// Purpose: display controller end of the two-wire link
// Assumes: link logic clocked by scl; frame memory in core domain
// Notes: start and stop are seen by oversampling in the core domain
`timescale 1ns/1ps
`default_nettype none
module oled_dev_end
  import oled_link_pkg::*;
#(
  parameter int MEM_BYTES = FRAME_BYTES,
  parameter int ADDR_W = $clog2(FRAME_BYTES)
)(
  // core clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // link
  oled_link_if.device link,
  // command decoder side
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  // frame memory scan port
  input wire logic [ADDR_W-1:0] mem_raddr_in,
  output logic [7:0] mem_rdata_out,
  output logic [ADDR_W-1:0] col_ptr_out,
  output logic two_wire_mode_out
);

  if (MEM_BYTES < 2 || (1 << ADDR_W) != MEM_BYTES)
  begin : g_chk
    $error("MEM_BYTES must be a power of two matching ADDR_W");
  end

  // ****************************************
  // core domain: pin sync and frame detect
  // ****************************************
  logic rst_n;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] strap_sync_q;
  logic sda_prev_q;
  logic armed_q;
  logic frame_rst_q;
  logic link_rst_n;
  logic start_seen;
  logic stop_seen;

  // chip init pin acts as a second reset source
  assign rst_n = rst_b_in & link.chip_init_pin_n;
  assign link_rst_n = rst_n & ~frame_rst_q;

  // two-flop synchronisers for the line levels and strap
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      strap_sync_q <= 2'h0;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      strap_sync_q <= {strap_sync_q[0], link.interface_select_strap};
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // data edges while clock high mark frame boundaries
  assign start_seen = scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
  assign stop_seen = scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];

  // strap follows pin after sync; low keeps the port dead
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      two_wire_mode_out <= 1'b0;
    else
      two_wire_mode_out <= strap_sync_q[1];
  end

  // link held in reset outside frames, released once scl falls
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
      frame_rst_q <= 1'b1;
    end
    else
    begin
      if (start_seen)
        armed_q <= two_wire_mode_out;
      else if (stop_seen || !two_wire_mode_out)
        armed_q <= 1'b0;
      if (start_seen || stop_seen || !two_wire_mode_out)
        frame_rst_q <= 1'b1;
      else if (armed_q && !scl_sync_q[1])
        frame_rst_q <= 1'b0;
    end
  end

  // ****************************************
  // link domain: byte framing
  // ****************************************
  link_state_t state_q;
  logic [3:0] bitcnt_q;
  logic [6:0] shift_q;
  logic [1:0] asel_sync_q;
  logic cont_q;
  logic dc_q;
  logic ack_q;
  logic sda_oe_q;
  logic [8:0] word_q;
  logic word_tgl_q;
  logic [7:0] rx_byte;
  logic [6:0] my_addr;
  logic [7:0] status_byte;
  logic byte_done;
  logic is_ctrl;

  assign rx_byte = {shift_q, link.sda};
  assign byte_done = (bitcnt_q == LAST_DATA_SLOT);
  assign is_ctrl = (rx_byte[5:0] == CTRL_ZERO_BITS);
  assign status_byte = {cont_q, dc_q, CTRL_ZERO_BITS};
  // address pick from synchronised select pin
  assign my_addr = asel_sync_q[1] ? TGT_ADDR_SEL_HIGH
    : TGT_ADDR_SEL_LOW;

  // select pin sync, kept across frames
  always_ff @(posedge link.scl or negedge rst_n)
  begin
    if (!rst_n)
      asel_sync_q <= 2'h0;
    else
      asel_sync_q <= {asel_sync_q[0], link.address_select_bit};
  end

  // bit counter and shifter
  always_ff @(posedge link.scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bitcnt_q <= 4'h0;
      shift_q <= 7'h00;
    end
    else
    begin
      shift_q <= rx_byte[6:0];
      if (bitcnt_q == ACK_SLOT)
        bitcnt_q <= 4'h0;
      else
        bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  // byte decode state machine
  always_ff @(posedge link.scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_q <= LS_ADDR;
      cont_q <= 1'b0;
      dc_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else if (bitcnt_q == ACK_SLOT)
    begin
      ack_q <= 1'b0;
      // host answer on a read: release means stop sending
      if (state_q == LS_READ && link.sda)
        state_q <= LS_IGNORE;
    end
    else if (byte_done)
    begin
      case (state_q)
        LS_ADDR:
        begin
          if (rx_byte[7:1] == my_addr)
          begin
            ack_q <= 1'b1;
            state_q <= (rx_byte[0] == DIR_READ) ? LS_READ : LS_CTRL;
          end
          else
            state_q <= LS_IGNORE;
        end
        LS_CTRL:
        begin
          ack_q <= 1'b1;
          if (is_ctrl)
          begin
            cont_q <= rx_byte[CONT_FLAG_POS];
            dc_q <= rx_byte[DC_FLAG_POS];
            state_q <= LS_PAYLOAD;
          end
        end
        LS_PAYLOAD:
        begin
          ack_q <= 1'b1;
          // continuation zero: stay in data-only stream
          state_q <= cont_q ? LS_CTRL : LS_PAYLOAD;
        end
        default:
          ack_q <= 1'b0;
      endcase
    end
  end

  // payload word handed to the core domain by toggle
  always_ff @(posedge link.scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_q <= 9'h000;
      word_tgl_q <= 1'b0;
    end
    else if (link_rst_n && byte_done &&
      (state_q == LS_PAYLOAD || (state_q == LS_CTRL && !is_ctrl)))
    begin
      word_q <= {dc_q, rx_byte};
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // data line drive on falling scl: ack slot or read bits
  always_ff @(negedge link.scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      sda_oe_q <= 1'b0;
    else if (state_q == LS_READ && bitcnt_q != ACK_SLOT)
      sda_oe_q <= ~status_byte[3'h7 - bitcnt_q[2:0]];
    else
      sda_oe_q <= ack_q && (bitcnt_q == ACK_SLOT);
  end

  assign link.dev_sda_oe = sda_oe_q;
  assign link.dev_sda_out = 1'b0;

  // ****************************************
  // core domain: command path and memory
  // ****************************************
  logic [1:0] tgl_sync_q;
  logic tgl_prev_q;
  logic word_evt;
  logic [7:0] mem [MEM_BYTES];

  assign word_evt = tgl_sync_q[1] ^ tgl_prev_q;

  // toggle synchroniser for the payload event
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_sync_q <= 2'h0;
      tgl_prev_q <= 1'b0;
    end
    else
    begin
      tgl_sync_q <= {tgl_sync_q[0], word_tgl_q};
      tgl_prev_q <= tgl_sync_q[1];
    end
  end

  // route by data/command flag, step pointer on memory writes
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_valid_out <= 1'b0;
      cmd_byte_out <= 8'h00;
      col_ptr_out <= '0;
    end
    else
    begin
      cmd_valid_out <= word_evt && !word_q[8];
      if (word_evt && !word_q[8])
        cmd_byte_out <= word_q[7:0];
      if (word_evt && word_q[8])
        col_ptr_out <= col_ptr_out + 1'b1;
    end
  end

  // frame memory write, no reset on storage
  always_ff @(posedge core_clk_in)
  begin
    if (word_evt && word_q[8])
      mem[col_ptr_out] <= word_q[7:0];
  end

  // scan read port, one cycle latency
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      mem_rdata_out <= 8'h00;
    else
      mem_rdata_out <= mem[mem_raddr_in];
  end

endmodule : oled_dev_end
`default_nettype wire

// file: logic/oled_host_end.sv
// Purpose: host controller end driving the two-wire link
// Assumes: software port with read data one cycle after the strobe
// Notes: one transfer per go; scl made from core clock by a divider
`timescale 1ns/1ps
`default_nettype none
module oled_host_end
  import oled_link_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
)(
  // core clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // software register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // link
  oled_link_if.host link
);

  if (QTR_CYC < MIN_QTR_CYC)
  begin : g_chk
    $error("QTR_CYC too small for the target's frame detector");
  end

  // ****************************************
  // registers and sync
  // ****************************************
  host_state_t state_q;
  host_op_t op_q;
  logic [15:0] div_q;
  logic tick;
  logic [1:0] qtr_q;
  logic [3:0] slot_q;
  logic [5:0] idx_q;
  logic [2:0] cfg_q;
  logic [7:0] data_q;
  logic [7:0] rx_q;
  logic nack_q;
  logic scl_q;
  logic sda_oe_q;
  logic [1:0] sda_sync_q;
  logic [7:0] cur_byte;
  logic reading;
  logic last_byte;
  logic go;

  assign tick = (div_q == 16'(QTR_CYC - 1));
  assign reading = (op_q == OP_READ) && (idx_q == 6'h01);
  assign go = reg_wr_in && (reg_addr_in == REG_CTRL) && (state_q == HS_IDLE)
    && (reg_wdata_in[2:0] != 3'h0);

  // byte for the current index
  always_comb
  begin
    cur_byte = data_q;
    if (idx_q == 6'h00)
      cur_byte = {(cfg_q[1] ? TGT_ADDR_SEL_HIGH : TGT_ADDR_SEL_LOW),
        op_q == OP_READ};
    else if (idx_q == 6'h01)
      cur_byte = {1'b0, (op_q == OP_INIT) ? 1'b0 : cfg_q[0],
        CTRL_ZERO_BITS};
    else if (op_q == OP_INIT)
      cur_byte = INIT_SEQ[5'(idx_q - 6'h02)];
  end

  assign last_byte = (op_q == OP_INIT) ? (idx_q == 6'(INIT_LEN + 1))
    : (op_q == OP_READ) ? (idx_q == 6'h01) : (idx_q == 6'h02);

  // data line sync for ack and read sampling
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sda_sync_q <= 2'h3;
    else
      sda_sync_q <= {sda_sync_q[0], link.sda};
  end

  // software registers; nack cleared by a new go only
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg_q <= CTRL_CFG_RESET;
      data_q <= 8'h00;
    end
    else if (reg_wr_in && reg_addr_in == REG_CTRL)
      cfg_q <= {reg_wdata_in[CTRL_INIT_N_POS], reg_wdata_in[CTRL_SA_POS],
        reg_wdata_in[CTRL_DC_POS]};
    else if (reg_wr_in && reg_addr_in == REG_DATA)
      data_q <= reg_wdata_in;
  end

  // read data in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 8'h00;
    else if (!reg_rd_in)
      reg_rdata_out <= 8'h00;
    else if (reg_addr_in == REG_CTRL)
      reg_rdata_out <= {2'h0, cfg_q[2], cfg_q[1], cfg_q[0], 3'h0};
    else if (reg_addr_in == REG_DATA)
      reg_rdata_out <= data_q;
    else if (reg_addr_in == REG_STATUS)
      reg_rdata_out <= {6'h00, nack_q, state_q != HS_IDLE};
    else
      reg_rdata_out <= rx_q;
  end

  // pins to the target
  assign link.chip_init_pin_n = cfg_q[2];
  assign link.address_select_bit = cfg_q[1];
  assign link.scl = scl_q;
  assign link.host_sda_oe = sda_oe_q;
  assign link.host_sda_out = 1'b0;

  // ****************************************
  // quarter-period divider
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_q <= 16'h0000;
    else if (state_q == HS_IDLE || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= HS_IDLE;
      op_q <= OP_WRITE;
      qtr_q <= 2'h0;
      slot_q <= 4'h0;
      idx_q <= 6'h00;
      nack_q <= 1'b0;
      rx_q <= 8'h00;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        HS_IDLE:
          if (go)
          begin
            op_q <= reg_wdata_in[CTRL_GO_INIT_POS] ? OP_INIT
              : reg_wdata_in[CTRL_GO_RD_POS] ? OP_READ : OP_WRITE;
            nack_q <= 1'b0;
            idx_q <= 6'h00;
            slot_q <= 4'h0;
            qtr_q <= 2'h0;
            state_q <= HS_START;
          end
        HS_START:
          if (tick)
          begin
            sda_oe_q <= 1'b1; // start: data falls, clock high
            state_q <= HS_BYTE;
          end
        HS_BYTE:
          if (tick)
          begin
            qtr_q <= qtr_q + 2'h1;
            case (qtr_q)
              2'h0: scl_q <= 1'b0;
              2'h1: sda_oe_q <= (slot_q != ACK_SLOT) && !reading
                && !cur_byte[3'h7 - slot_q[2:0]];
              2'h2: scl_q <= 1'b1;
              default:
              begin
                if (slot_q != ACK_SLOT)
                begin
                  if (reading)
                    rx_q <= {rx_q[6:0], sda_sync_q[1]};
                  slot_q <= slot_q + 4'h1;
                end
                else
                begin
                  slot_q <= 4'h0;
                  idx_q <= idx_q + 6'h01;
                  if (!reading && sda_sync_q[1])
                  begin
                    nack_q <= 1'b1;
                    state_q <= HS_STOP;
                  end
                  else if (last_byte)
                    state_q <= HS_STOP;
                end
              end
            endcase
          end
        default:
          if (tick)
          begin
            qtr_q <= qtr_q + 2'h1;
            case (qtr_q)
              2'h0: scl_q <= 1'b0;
              2'h1: sda_oe_q <= 1'b1;
              2'h2: scl_q <= 1'b1;
              default:
              begin
                sda_oe_q <= 1'b0; // stop: data rises, clock high
                state_q <= HS_IDLE;
              end
            endcase
          end
      endcase
    end
  end

endmodule : oled_host_end
`default_nettype wire

// file: bench/oled_link_sva.sv
// Purpose: checker for the two-wire display link
// Assumes: core clock oversamples scl and sda
// Notes: bit slots are counted from each start condition
`timescale 1ns/1ps
`default_nettype none
module oled_link_sva (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic address_select_bit,
  input wire logic chip_init_pin_n,
  input wire logic interface_select_strap
);
  logic scl_q, sda_q, hit_q, dir_q;
  logic [4:0] cnt_q;
  logic [7:0] addr_q;
  logic rise_w, start_w, stop_w, match_w;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // line events as seen by the core clock
  assign rise_w = scl & ~scl_q;
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w = scl & scl_q & ~sda_q & sda;
  assign match_w = (addr_q[7:1] == (address_select_bit ? 7'h3D : 7'h3C))
    & interface_select_strap & chip_init_pin_n;

  // previous line levels
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // rising clock count since start, parked at all ones when idle
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_q <= 5'h1F;
    else if (start_w)
      cnt_q <= 5'h00;
    else if (stop_w)
      cnt_q <= 5'h1F;
    else if (rise_w && cnt_q != 5'h1F)
      cnt_q <= cnt_q + 5'h01;
  end

  // address byte and its verdict
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      addr_q <= 8'h00;
      hit_q <= 1'b0;
      dir_q <= 1'b0;
    end
    else if (rise_w && cnt_q < 5'h08)
      addr_q <= {addr_q[6:0], sda};
    else if (rise_w && cnt_q == 5'h08)
    begin
      hit_q <= match_w;
      dir_q <= addr_q[0];
    end
  end

  addr_ack_a: assert property (
    rise_w && cnt_q == 5'h08 |-> sda == !match_w)
    else $error("address acknowledge wrong");
  dir_ack_a: assert property (
    rise_w && cnt_q == 5'h11 && hit_q |-> sda == dir_q)
    else $error("second acknowledge does not follow direction");
  ctrl_zero_a: assert property (
    rise_w && hit_q && cnt_q inside {[5'h0B:5'h10]} |-> !sda)
    else $error("control byte low bits not zero");
  byte_ack_a: assert property (
    rise_w && cnt_q == 5'h1A && hit_q && !dir_q |-> !sda)
    else $error("byte after control not acknowledged");
  strap_quiet_a: assert property (
    !interface_select_strap [*4] |-> !dev_sda_oe)
    else $error("target drives with strap low");
  init_quiet_a: assert property (
    !chip_init_pin_n |-> !dev_sda_oe)
    else $error("target drives while held in init");
  dev_edge_a: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("target changed data with clock high");
  early_drive_a: assert property (
    cnt_q < 5'h08 |-> !dev_sda_oe)
    else $error("target drives during address");
endmodule : oled_link_sva
`default_nettype wire

// file: bench/oled_i2c_cmd_data_port_bench.sv
// Purpose: bench for host and display ends of the link
// Assumes: quarter bit of 8 core cycles
// Notes: a second link is bit-banged by the bench
`timescale 1ns/1ps
`default_nettype none
module oled_i2c_cmd_data_port_bench
  import oled_link_pkg::*;
;
  logic core_clk, rst_b, reg_wr, reg_rd, mode, ack, cmd_valid;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rdv, cmd_byte, cmd_byte2;
  logic [7:0] mem_rdata, mem_rdata2;
  logic [12:0] mem_raddr, col_ptr, col_ptr2, p;
  logic [7:0] cmd_log [$];
  int bad_count, total_checks, cycles, n0;

  // ****************************************
  // ends, links and checker
  // ****************************************
  oled_link_if l1 ();
  oled_link_if l2 ();
  oled_host_end #(.QTR_CYC(8)) u_oled_host_end (.core_clk_in(core_clk),
    .rst_b_in(rst_b), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .link(l1));
  oled_dev_end u_oled_dev_end (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .link(l1), .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte),
    .mem_raddr_in(mem_raddr), .mem_rdata_out(mem_rdata),
    .col_ptr_out(col_ptr), .two_wire_mode_out(mode));
  oled_dev_end u_oled_dev_end_2 (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .link(l2), .cmd_valid_out(), .cmd_byte_out(cmd_byte2),
    .mem_raddr_in(13'h0000), .mem_rdata_out(mem_rdata2),
    .col_ptr_out(col_ptr2), .two_wire_mode_out());
  oled_link_sva u_oled_link_sva (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .scl(l1.scl), .sda(l1.sda), .dev_sda_oe(l1.dev_sda_oe),
    .address_select_bit(l1.address_select_bit),
    .chip_init_pin_n(l1.chip_init_pin_n),
    .interface_select_strap(l1.interface_select_strap));

  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // command log and hang guard
  always @(posedge core_clk)
  begin
    if (cmd_valid === 1'b1)
      cmd_log.push_back(cmd_byte);
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd

  // start an operation and poll busy until it clears
  task go(input logic [7:0] c);
    wr(REG_CTRL, c);
    rdv = 8'h01;
    while (rdv[0] !== 1'b0)
      rd(REG_STATUS);
  endtask : go

  task memchk(input logic [12:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    mem_raddr <= a;
    repeat (2) @(posedge core_clk);
    #1 check(16'(mem_rdata), 16'(exp));
  endtask : memchk

  task qw;
    repeat (8) @(posedge core_clk);
  endtask : qw

  // one byte on the second link, then the acknowledge slot
  task bb_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      l2.scl <= 1'b0;
      qw();
      l2.host_sda_oe <= ~b[i];
      qw();
      l2.scl <= 1'b1;
      qw();
      qw();
    end
    l2.scl <= 1'b0;
    qw();
    l2.host_sda_oe <= 1'b0;
    qw();
    l2.scl <= 1'b1;
    qw();
    ack = ~l2.sda;
    qw();
  endtask : bb_byte

  task bb_stop;
    l2.scl <= 1'b0;
    qw();
    l2.host_sda_oe <= 1'b1;
    qw();
    l2.scl <= 1'b1;
    qw();
    l2.host_sda_oe <= 1'b0;
    qw();
  endtask : bb_stop

  // ****************************************
  // scenarios
  // ****************************************
  task t_write;
    wr(REG_DATA, 8'hA5);
    n0 = cmd_log.size();
    go(8'h21);
    check(16'(cmd_log.size()), 16'(n0 + 1));
    check(16'(cmd_byte), 16'h00A5);
    p = col_ptr;
    wr(REG_DATA, 8'h3C);
    go(8'h29);
    wr(REG_DATA, 8'hC3);
    go(8'h29);
    check(16'(col_ptr), 16'(p + 13'h0002));
    check(16'(cmd_log.size()), 16'(n0 + 1));
    memchk(p, 8'h3C);
    memchk(p + 13'h0001, 8'hC3);
    wr(REG_DATA, 8'h77);
    go(8'h39);
    check(16'(col_ptr), 16'(p + 13'h0003));
    go(8'h22);
    rd(REG_RXDATA);
    check(16'(rdv), 16'h0000);
    $display("write and read test done");
  endtask : t_write

  task t_init;
    n0 = cmd_log.size();
    go(8'h24);
    check(16'(cmd_log.size()), 16'(n0 + 30));
    check(16'({cmd_log[n0], cmd_log[n0+1]}), 16'hAE15);
    check(16'({cmd_log[n0+3], cmd_log[n0+4]}), 16'h3F75);
    check(16'({cmd_log[n0+22], cmd_log[n0+23]}), 16'hB300);
    check(16'({cmd_log[n0+18], cmd_log[n0+19]}), 16'hAB01);
    check(16'({cmd_log[n0+28], cmd_log[n0+29]}), 16'hB60F);
    go(8'h22);
    rd(REG_RXDATA);
    check(16'(rdv), 16'h0000);
    $display("init stream test done");
  endtask : t_init

  task t_pins;
    @(posedge core_clk);
    l1.interface_select_strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(16'(mode), 16'h0000);
    p = col_ptr;
    go(8'h29);
    rd(REG_STATUS);
    check(16'(rdv & 8'h03), 16'h0002);
    check(16'(col_ptr), 16'(p));
    l1.interface_select_strap <= 1'b1;
    wr(REG_CTRL, 8'h08);
    repeat (4) @(posedge core_clk);
    check(16'(col_ptr), 16'h0000);
    rd(REG_CTRL);
    check(16'(rdv), 16'h0008);
    go(8'h29);
    check(16'(col_ptr), 16'h0001);
    $display("strap and init pin test done");
  endtask : t_pins

  task t_far;
    // start: data low a full quarter before the clock falls
    l2.host_sda_oe <= 1'b1;
    qw();
    bb_byte(8'h7A);
    check(16'(ack), 16'h0000);
    bb_stop();
    check(16'(col_ptr2), 16'h0000);
    l2.host_sda_oe <= 1'b1;
    qw();
    bb_byte(8'h78);
    check(16'(ack), 16'h0001);
    bb_byte(8'h80);
    bb_byte(8'hAE);
    bb_byte(8'hC0);
    bb_byte(8'h5A);
    check(16'(ack), 16'h0001);
    bb_stop();
    check(16'(cmd_byte2), 16'h00AE);
    check(16'(col_ptr2), 16'h0001);
    check(16'(mem_rdata2), 16'h005A);
    $display("bit-banged link test done");
  endtask : t_far

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // reset, then the scenarios in turn
  initial
  begin
    rst_b = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mem_raddr = 13'h0000;
    l1.interface_select_strap = 1'b1;
    l2.scl = 1'b1;
    l2.host_sda_out = 1'b0;
    l2.host_sda_oe = 1'b0;
    l2.address_select_bit = 1'b0;
    l2.chip_init_pin_n = 1'b1;
    l2.interface_select_strap = 1'b1;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_write();
    t_init();
    t_pins();
    t_far();
    end_of_test();
  end
endmodule : oled_i2c_cmd_data_port_bench
`default_nettype wire
